// [logic/sram_port_pkg.sv]
package sram_port_pkg;

	// Array shape
	localparam int ADDR_WIDTH = 19;
	localparam int LANES = 4;
	localparam int LANE_WIDTH = 9;
	localparam int DATA_WIDTH = LANES * LANE_WIDTH;
	localparam int BURST_BITS = 2;

	// Value after reset and lane masks
	localparam logic [BURST_BITS-1:0] BURST_RESET = 2'h0;
	localparam logic [LANES-1:0] LANE_MASK_ALL = 4'hF;
	localparam logic [LANES-1:0] LANE_MASK_NONE = 4'h0;

	// Clock to data delay, in picoseconds, and its cycle count
	localparam int CLK_PERIOD_PS = 10000;
	localparam int CLOCK_TO_DATA_DELAY_PS = 6500;
	localparam int CLOCK_TO_DATA_CYCLES =
		(CLOCK_TO_DATA_DELAY_PS / CLK_PERIOD_PS < 1) ? 1 :
		CLOCK_TO_DATA_DELAY_PS / CLK_PERIOD_PS;

	// Burst order strap values
	typedef enum logic {
		ORDER_LINEAR,
		ORDER_INTERLEAVED
	} burst_order_t;

	// Kind of cycle decoded at a clock rise
	typedef enum logic [1:0] {
		CYC_NONE,
		CYC_DESELECT,
		CYC_READ,
		CYC_WRITE
	} cycle_kind_t;

	// Burst address from start value and step count
	function automatic logic [BURST_BITS-1:0] burst_addr(
		input burst_order_t order,
		input logic [BURST_BITS-1:0] start,
		input logic [BURST_BITS-1:0] count);
		logic [BURST_BITS-1:0] sum;
		sum = BURST_BITS'(start + count);
		burst_addr = (order == ORDER_INTERLEAVED) ? (start ^ count) : sum;
	endfunction

endpackage

// [logic/burst_address_counter.sv]
`timescale 1ns/10ps
module burst_address_counter
	import sram_port_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Control
	input wire logic load_in,
	input wire logic [BURST_BITS-1:0] load_value_in,
	input wire logic step_in,
	input wire burst_order_t order_in,
	// Burst address
	output logic [BURST_BITS-1:0] burst_low_out,
	output logic [BURST_BITS-1:0] stepped_low_out,
	output logic [BURST_BITS-1:0] burst_count_out
);

	logic [BURST_BITS-1:0] start_low;
	logic [BURST_BITS-1:0] count;

	// Start value capture and wraparound step count
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			start_low <= BURST_RESET;
			count <= BURST_RESET;
		end else if (load_in) begin
			start_low <= load_value_in;
			count <= BURST_RESET;
		end else if (step_in) begin
			count <= BURST_BITS'(count + 2'h1);
		end
	end

	// Current and next address of the burst
	assign burst_low_out = burst_addr(order_in, start_low, count);
	assign stepped_low_out =
		burst_addr(order_in, start_low, BURST_BITS'(count + 2'h1));
	assign burst_count_out = count;

endmodule

// [logic/flow_through_burst_sram_port.sv]
`timescale 1ns/10ps
// Contract
// - All synchronous inputs are taken on the rising system clock edge.
// - All chip selects active plus either strobe low starts an access.
// - Read data appears flow-through in the cycle the access started.
// - Processor strobe is ignored while first chip select is high.
// - Processor-strobe start loads address and ignores all write controls.
// - Write indicated on the next rise after processor start is stored.
// - Controller strobe with write controls writes in the same cycle.
// - Controller-strobe write address goes to counter and core.
// - Byte writes need the byte write gate and lane selects.
// - Global write stores all four lanes whatever the lane controls.
// - Data drivers turn off once a write is seen, despite output enable.
// - Two-bit wraparound counter captures start and generates follow-ons.
// - Counter loads from the two low address bits only.
// - Counter advances only under the burst step input.
// - Strap low means linear order, high or open means interleaved.
// - Interleaved address is start XOR burst count.
// - Linear address is start plus count, modulo four.
// - Test data output changes on the test clock falling edge.
// - Test data input and mode select are sampled on test clock rise.
// - Outputs stay off during writes and while deselected.
module flow_through_burst_sram_port
	import sram_port_pkg::*;
#(
	parameter int ADDR_W = ADDR_WIDTH,
	parameter int DATA_W = DATA_WIDTH
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// Address and selects
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic chip_select_first_n_in,
	input wire logic chip_select_second_in,
	input wire logic chip_select_third_n_in,
	// Burst control
	input wire logic processor_addr_strobe_n_in,
	input wire logic controller_addr_strobe_n_in,
	input wire logic burst_step_n_in,
	input wire logic burst_order_in,
	// Write control
	input wire logic global_write_n_in,
	input wire logic byte_write_gate_n_in,
	input wire logic [LANES-1:0] byte_lane_select_n_in,
	// Data lines
	input wire logic output_drive_enable_n_in,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_out,
	// Serial test pins
	input wire logic test_clk_in,
	input wire logic test_mode_select_in,
	input wire logic test_data_in,
	output logic test_data_out
);

	localparam int DEPTH = 1 << ADDR_W;
	localparam int read_delay = CLOCK_TO_DATA_CYCLES;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	////////////////////////////////////////////////////////////////////////
	// Asynchronous and static pins

	logic oe_meta_n;
	logic oe_sync_n;
	logic order_meta;
	logic order_sync;
	burst_order_t order;

	// Output enable and strap through two flops
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			oe_meta_n <= 1'b1;
			oe_sync_n <= 1'b1;
			order_meta <= 1'b1;
			order_sync <= 1'b1;
		end else begin
			oe_meta_n <= output_drive_enable_n_in;
			oe_sync_n <= oe_meta_n;
			order_meta <= burst_order_in;
			order_sync <= order_meta;
		end
	end

	// Strap level picks the order, open defaults to interleaved
	assign order = order_sync ? ORDER_INTERLEAVED : ORDER_LINEAR;

	////////////////////////////////////////////////////////////////////////
	// Cycle decode at the clock rise

	logic chips_all;
	logic write_req;
	logic [LANES-1:0] lane_mask;
	cycle_kind_t kind;
	logic load;
	logic step;
	logic start_proc;
	logic selected;

	// All three chip selects active
	assign chips_all = !chip_select_first_n_in && chip_select_second_in &&
		!chip_select_third_n_in;

	// Write indication and selected lanes
	always_comb begin
		write_req = !global_write_n_in ||
			(!byte_write_gate_n_in && (byte_lane_select_n_in != LANE_MASK_ALL));
		if (!global_write_n_in) begin
			lane_mask = LANE_MASK_ALL;
		end else if (!byte_write_gate_n_in) begin
			lane_mask = ~byte_lane_select_n_in;
		end else begin
			lane_mask = LANE_MASK_NONE;
		end
	end

	// Strobe priority: processor first, then controller, then burst
	always_comb begin
		kind = CYC_NONE;
		load = 1'b0;
		step = 1'b0;
		start_proc = 1'b0;
		if (!chip_select_first_n_in && !processor_addr_strobe_n_in) begin
			if (chips_all) begin
				kind = CYC_READ;
				load = 1'b1;
				start_proc = 1'b1;
			end else begin
				kind = CYC_DESELECT;
			end
		end else if (!controller_addr_strobe_n_in) begin
			if (chips_all) begin
				kind = write_req ? CYC_WRITE : CYC_READ;
				load = 1'b1;
			end else begin
				kind = CYC_DESELECT;
			end
		end else if (selected) begin
			step = !burst_step_n_in;
			kind = write_req ? CYC_WRITE : CYC_READ;
		end
	end

	// Device stays selected until a deselect cycle
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			selected <= 1'b0;
		end else if (kind == CYC_DESELECT) begin
			selected <= 1'b0;
		end else if (kind != CYC_NONE) begin
			selected <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address register and burst counter

	logic [ADDR_W-1:0] addr_reg;
	logic [BURST_BITS-1:0] burst_low;
	logic [BURST_BITS-1:0] stepped_low;
	logic [BURST_BITS-1:0] burst_count;
	logic [BURST_BITS-1:0] eff_low;
	logic [ADDR_W-1:0] eff_addr;

	burst_address_counter u_burst (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.load_in(load),
		.load_value_in(addr_in[BURST_BITS-1:0]),
		.step_in(step),
		.order_in(order),
		.burst_low_out(burst_low),
		.stepped_low_out(stepped_low),
		.burst_count_out(burst_count)
	);

	// Upper address bits held for the whole burst
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			addr_reg <= '0;
		end else if (load) begin
			addr_reg <= addr_in;
		end
	end

	// Address used by this cycle: new, next or current
	always_comb begin
		if (load) begin
			eff_low = addr_in[BURST_BITS-1:0];
		end else if (step) begin
			eff_low = stepped_low;
		end else begin
			eff_low = burst_low;
		end
		if (load) begin
			eff_addr = addr_in;
		end else begin
			eff_addr = {addr_reg[ADDR_W-1:BURST_BITS], eff_low};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory core

	logic [DATA_W-1:0] mem [0:DEPTH-1];

	// Self-timed write of the selected lanes, data taken at the rise
	always_ff @(posedge clk_sys_in) begin
		if (!srst_in && kind == CYC_WRITE) begin
			for (int i = 0; i < LANES; i++) begin
				if (lane_mask[i]) begin
					mem[eff_addr][i*LANE_WIDTH +: LANE_WIDTH] <=
						data_in[i*LANE_WIDTH +: LANE_WIDTH];
				end
			end
		end
	end

	// Flow-through read data, updated on every read cycle
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			data_out <= '0;
		end else if (kind == CYC_READ) begin
			data_out <= mem[eff_addr];
		end
	end

	// Drivers only for reads with output enable low
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			data_oe_out <= 1'b0;
		end else begin
			data_oe_out <= (kind == CYC_READ) && !oe_sync_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial test pins

	logic tck_meta;
	logic tck_sync;
	logic tck_prev;
	logic tms_meta;
	logic tms_sync;
	logic tdi_meta;
	logic tdi_sync;
	logic bypass_bit;
	logic tck_rise;
	logic tck_fall;

	// Test pins through two flops
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			tck_meta <= 1'b0;
			tck_sync <= 1'b0;
			tck_prev <= 1'b0;
			tms_meta <= 1'b1;
			tms_sync <= 1'b1;
			tdi_meta <= 1'b1;
			tdi_sync <= 1'b1;
		end else begin
			tck_meta <= test_clk_in;
			tck_sync <= tck_meta;
			tck_prev <= tck_sync;
			tms_meta <= test_mode_select_in;
			tms_sync <= tms_meta;
			tdi_meta <= test_data_in;
			tdi_sync <= tdi_meta;
		end
	end

	assign tck_rise = tck_sync && !tck_prev;
	assign tck_fall = !tck_sync && tck_prev;

	// Sample on rise, mode select high clears the cell
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			bypass_bit <= 1'b0;
		end else if (tck_rise) begin
			bypass_bit <= tms_sync ? 1'b0 : tdi_sync;
		end
	end

	// Shift out on fall
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			test_data_out <= 1'b0;
		end else if (tck_fall) begin
			test_data_out <= bypass_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_proc_start;
		start_proc;
	endsequence

	sequence s_write_follow;
		processor_addr_strobe_n_in && controller_addr_strobe_n_in &&
			burst_step_n_in && write_req;
	endsequence

	sequence s_inter_load;
		load && order == ORDER_INTERLEAVED;
	endsequence

	a_write_drive_off: assert property (
		kind == CYC_WRITE |=> !data_oe_out)
		else $error("drivers on after a write cycle");

	a_deselect_drive_off: assert property (
		kind == CYC_DESELECT |=> !data_oe_out && !selected)
		else $error("drivers on or still selected after deselect");

	a_proc_strobe_ignored: assert property (
		chip_select_first_n_in && !processor_addr_strobe_n_in &&
		controller_addr_strobe_n_in && !selected |=> !selected)
		else $error("processor strobe taken with first select high");

	a_read_flow_data: assert property (
		kind == CYC_READ && !oe_sync_n |-> ##read_delay
		(data_oe_out && data_out == mem[$past(eff_addr)]))
		else $error("read data not presented in the access cycle");

	a_proc_no_write: assert property (
		s_proc_start |-> kind == CYC_READ && eff_addr == addr_in)
		else $error("processor start did not read the new address");

	a_proc_then_write: assert property (
		s_proc_start ##1 s_write_follow |->
		kind == CYC_WRITE && eff_addr == $past(addr_in))
		else $error("write after processor start missed captured address");

	a_ctrl_write_same: assert property (
		controller_addr_strobe_n_in == 1'b0 && processor_addr_strobe_n_in &&
		chips_all && write_req |-> kind == CYC_WRITE && load)
		else $error("controller write not started in its cycle");

	a_global_all_lanes: assert property (
		kind == CYC_WRITE && !global_write_n_in |->
		lane_mask == LANE_MASK_ALL)
		else $error("global write did not select all lanes");

	a_lane_gating: assert property (
		kind == CYC_WRITE && global_write_n_in |->
		lane_mask == ~byte_lane_select_n_in && !byte_write_gate_n_in)
		else $error("byte lanes written without gate and selects");

	a_burst_linear: assert property (
		step && !load && order == ORDER_LINEAR |=>
		burst_low == BURST_BITS'($past(burst_low) + 2'h1))
		else $error("linear burst did not increment");

	a_burst_interleave: assert property (
		s_inter_load ##1 (step && !load && order == ORDER_INTERLEAVED)[*3]
		|=> burst_low == ($past(addr_in[BURST_BITS-1:0], 4) ^ 2'h3))
		else $error("interleaved fourth address wrong");

	a_burst_suspend: assert property (
		!load && !step |=> $stable(burst_low) && $stable(burst_count))
		else $error("burst address moved without a step");

	a_test_out_fall: assert property (
		$changed(test_data_out) |-> $past(tck_fall))
		else $error("test data output changed off a falling edge");

endmodule

// [verification/bus_master_model.sv]
`timescale 1ns/10ps
module bus_master_model (
	// Clock
	input wire logic clk_sys_in,
	// Address, selects and strobes
	output logic [5:0] addr_out,
	output logic chip_select_first_n_out,
	output logic chip_select_second_out,
	output logic chip_select_third_n_out,
	output logic processor_addr_strobe_n_out,
	output logic controller_addr_strobe_n_out,
	output logic burst_step_n_out,
	// Write controls and data
	output logic global_write_n_out,
	output logic byte_write_gate_n_out,
	output logic [3:0] byte_lane_select_n_out,
	output logic output_drive_enable_n_out,
	output logic [35:0] data_out
);
	// Packed controls: selects, strobes, step, writes, lanes
	logic [11:0] ctl = 12'hB7F;
	assign {chip_select_first_n_out, chip_select_second_out,
		chip_select_third_n_out, processor_addr_strobe_n_out,
		controller_addr_strobe_n_out, burst_step_n_out,
		global_write_n_out, byte_write_gate_n_out,
		byte_lane_select_n_out} = ctl;

	// Idle bus at time zero
	initial begin
		addr_out = 6'h00;
		output_drive_enable_n_out = 1'b1;
		data_out = 36'h0;
	end

	// One bus cycle, launched at a rising edge
	task automatic cyc(input logic [11:0] c, input logic [5:0] a,
		input logic [35:0] d);
		@(posedge clk_sys_in);
		// Controller read start keeps all write inputs off
		ctl <= (!c[7] && c[8] && c[5] && c[4]) ? (c | 12'h00F) : c;
		addr_out <= a;
		// Undriven data lines show a moving pattern
		if (!c[5] || !c[4]) data_out <= d;
		else data_out <= ~data_out;
	endtask

	// Output enable changes only while deselected, then settles
	task automatic oe(input logic v);
		cyc(12'hB7F, addr_out, data_out);
		output_drive_enable_n_out <= v;
		repeat (3) @(posedge clk_sys_in);
	endtask
endmodule

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic burst_order_in = 1'b1;
	logic test_clk_in = 1'b0;
	logic test_mode_select_in = 1'b0;
	logic test_data_in = 1'b0;
	logic [5:0] addr_in;
	logic chip_select_first_n_in, chip_select_second_in;
	logic chip_select_third_n_in, processor_addr_strobe_n_in;
	logic controller_addr_strobe_n_in, burst_step_n_in;
	logic global_write_n_in, byte_write_gate_n_in;
	logic output_drive_enable_n_in, data_oe_out, test_data_out;
	logic [3:0] byte_lane_select_n_in;
	logic [35:0] data_in, data_out;
	logic [35:0] sh [64];
	logic [35:0] q [$];
	int miscompares = 0;
	int checked = 0;

	flow_through_burst_sram_port #(.ADDR_W(6))
		flow_through_burst_sram_port_inst (.clk_sys_in, .srst_in,
		.addr_in, .chip_select_first_n_in, .chip_select_second_in,
		.chip_select_third_n_in, .processor_addr_strobe_n_in,
		.controller_addr_strobe_n_in, .burst_step_n_in, .burst_order_in,
		.global_write_n_in, .byte_write_gate_n_in, .byte_lane_select_n_in,
		.output_drive_enable_n_in, .data_in, .data_out, .data_oe_out,
		.test_clk_in, .test_mode_select_in, .test_data_in, .test_data_out);

	bus_master_model bus_master_model_inst (.clk_sys_in,
		.addr_out(addr_in), .chip_select_first_n_out(chip_select_first_n_in),
		.chip_select_second_out(chip_select_second_in),
		.chip_select_third_n_out(chip_select_third_n_in),
		.processor_addr_strobe_n_out(processor_addr_strobe_n_in),
		.controller_addr_strobe_n_out(controller_addr_strobe_n_in),
		.burst_step_n_out(burst_step_n_in),
		.global_write_n_out(global_write_n_in),
		.byte_write_gate_n_out(byte_write_gate_n_in),
		.byte_lane_select_n_out(byte_lane_select_n_in),
		.output_drive_enable_n_out(output_drive_enable_n_in),
		.data_out(data_in));

	always #5 clk_sys_in = ~clk_sys_in;

	////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic check(input string n, input logic [35:0] s, e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic print_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Each driven read takes the oldest expectation
	always @(negedge clk_sys_in) begin
		if (data_oe_out === 1'b1) begin
			if (q.size() == 0) check("data_oe_out", 36'h1, 36'h0);
			else check("read data", data_out, q.pop_front());
		end
	end

	function automatic logic [35:0] rnd();
		return 36'({$urandom(), $urandom()});
	endfunction

	task automatic rd(input logic [11:0] c, input logic [5:0] a);
		bus_master_model_inst.cyc(c, a, rnd());
		if (!output_drive_enable_n_in) q.push_back(sh[a]);
	endtask

	task automatic wr(input logic [11:0] c, input logic [5:0] a,
		input logic [3:0] m);
		logic [35:0] d;
		d = rnd();
		bus_master_model_inst.cyc(c, a, d);
		for (int l = 0; l < 4; l++)
			if (m[l]) sh[a][9*l+:9] = d[9*l+:9];
	endtask

	task automatic do_reset();
		@(posedge clk_sys_in);
		srst_in <= 1'b1;
		repeat (5) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
	endtask

	// Hang guard
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		miscompares++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [1:0] s, n;
		logic [3:0] hi;
		logic v, p;
		void'($urandom(32'hFF95C6DD));
		do_reset();
		@(negedge clk_sys_in);
		check("data_out", data_out, 36'h0);
		check("data_oe_out", 36'(data_oe_out), 36'h0);
		$display("test reset done");
		bus_master_model_inst.oe(1'b1);
		for (int i = 0; i < 64; i++)
			wr(i[0] ? 12'h545 : 12'h55F, 6'(i), 4'hF);
		for (int m = 1; m < 16; m++)
			wr({8'h56, ~4'(m)}, 6'(m), 4'(m));
		bus_master_model_inst.cyc(12'h4DF, 6'h14, rnd());
		wr(12'hBEE, 6'h14, 4'h1);
		bus_master_model_inst.oe(1'b0);
		bus_master_model_inst.cyc(12'hCFF, 6'h14, 36'h0);
		rd(12'h45F, 6'h15);
		for (int i = 0; i < 64; i++)
			rd(i[0] ? 12'h57F : 12'h4FF, 6'(i));
		bus_master_model_inst.cyc(12'hB7F, 6'h00, 36'h0);
		$display("test single access done");
		for (int o = 0; o < 2; o++) begin
			burst_order_in <= o[0];
			do_reset();
			for (int j = 0; j < 4; j++) begin
				s = 2'(j);
				hi = 4'($urandom());
				rd(s[0] ? 12'h57F : 12'h4FF, {hi, s});
				for (int k = 1; k < 4; k++) begin
					n = o[0] ? s ^ 2'(k) : s + 2'(k);
					rd(12'hBBF, {hi, n});
					if (k == 3) rd(12'hBFF, {hi, n});
				end
				bus_master_model_inst.cyc(12'hB7F, 6'h00, 36'h0);
			end
		end
		$display("test bursts done");
		for (int i = 0; i < 4; i++) begin
			p = test_data_out;
			v = 1'($urandom());
			@(posedge clk_sys_in);
			test_data_in <= v;
			test_mode_select_in <= i[1];
			repeat (2) @(posedge clk_sys_in);
			test_clk_in <= 1'b1;
			repeat (6) @(posedge clk_sys_in);
			@(negedge clk_sys_in);
			check("test_data_out", 36'(test_data_out), 36'(p));
			@(posedge clk_sys_in);
			test_clk_in <= 1'b0;
			repeat (6) @(posedge clk_sys_in);
			@(negedge clk_sys_in);
			check("test_data_out", 36'(test_data_out),
				36'(v & ~i[1]));
		end
		$display("test serial pins done");
		repeat (3) @(posedge clk_sys_in);
		check("pending reads", 36'(q.size()), 36'h0);
		print_verdict();
	end
endmodule
